// *** hdl/dual_timer_capture_pwm.v ***
`include "dual_timer_map.vh"
`default_nettype none
module dual_timer_capture_pwm #(
    parameter HALF_W = 16,
    parameter RTC_DIV = `RTC_DIV
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire debug_halt,
    input wire rtc_slow_clk,
    input wire cap_a_in,
    output wire cap_a_out,
    output wire cap_a_oe,
    input wire cap_b_in,
    output wire cap_b_out,
    output wire cap_b_oe,
    output wire trig_a,
    output wire trig_b,
    output wire irq
);
    // ****************************************
    // Register state
    // ****************************************
    reg [1:0] cfg_reg; // Top-level mode
    reg [5:0] mode_a_reg; // Half mode [2:0], edge [5:4]
    reg [5:0] mode_b_reg;
    reg [15:0] ctl_reg; // Enable, invert, stall, trigger
    reg [31:0] load_a_reg; // Full width used by wide modes
    reg [HALF_W-1:0] load_b_reg;
    reg [31:0] match_a_reg;
    reg [HALF_W-1:0] match_b_reg;
    reg [31:0] imr_reg; // Interrupt source enables
    reg [31:0] ris_reg; // Sticky raw status
    reg [31:0] wide_reg; // Wide down-counter or seconds count
    reg wide_stop_reg; // Wide one-shot expired
    reg wide_to_reg; // Wide timeout pulse
    reg rtc_hit_reg; // Seconds match pulse
    reg rtc_s1_reg; // First slow-clock stage, read only by the next
    reg rtc_s2_reg;
    reg rtc_s3_reg;
    reg [31:0] prescale_reg; // Slow-edge divider to seconds

    // ****************************************
    // Bus decode
    // ****************************************
    wire setup = psel & ~penable;
    wire wr = psel & penable & pwrite;
    // Decoder shared by read and write paths
    function mapped;
        input [7:0] a;
        begin
            mapped = (a[1:0] == 2'b00) && (a <= `TMR_VAL_B_OFS);
        end
    endfunction
    function hit;
        input [7:0] a;
        input [7:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction
    assign pready = 1'b1; // Zero wait states
    assign pslverr = psel & penable & ~mapped(paddr); // Unmapped is an error
    wire wr_ok = wr & mapped(paddr);

    // Control field pick-outs
    wire pair = (cfg_reg == `TOP_PAIR);
    wire en_a = ctl_reg[`CTL_EN];
    wire en_b = ctl_reg[`CTL_EN + `CTL_B_SHIFT];
    wire halt_a = ctl_reg[`CTL_STALL] & debug_halt;
    wire halt_b = ctl_reg[`CTL_STALL + `CTL_B_SHIFT] & debug_halt;
    wire load_a_wr = wr_ok & hit(paddr, `TMR_LOAD_A_OFS);
    wire load_b_wr = wr_ok & hit(paddr, `TMR_LOAD_B_OFS);

    // ****************************************
    // Half counters
    // ****************************************
    wire [HALF_W-1:0] cnt_a;
    wire [HALF_W-1:0] cnt_b;
    wire to_a, ev_a, cm_a, pwm_a;
    wire to_b, ev_b, cm_b, pwm_b;

    // Halves only run in pair mode; wide modes use the wide counter
    timer_half #(.WIDTH(HALF_W)) u_first_half_counter (
        .pclk(pclk),
        .presetn(presetn),
        .run(pair & en_a & ~halt_a),
        .mode(mode_a_reg[2:0]),
        .edge_sel(mode_a_reg[5:4]),
        .load_val(load_a_wr ? pwdata[HALF_W-1:0] : load_a_reg[HALF_W-1:0]),
        .load_wr(load_a_wr & pair),
        .match_val(match_a_reg[HALF_W-1:0]),
        .pin_in(cap_a_in),
        .count_reg(cnt_a),
        .timeout_pulse(to_a),
        .cap_event_pulse(ev_a),
        .cap_match_pulse(cm_a),
        .pwm_level(pwm_a)
    );
    timer_half #(.WIDTH(HALF_W)) u_second_half_counter (
        .pclk(pclk),
        .presetn(presetn),
        .run(pair & en_b & ~halt_b),
        .mode(mode_b_reg[2:0]),
        .edge_sel(mode_b_reg[5:4]),
        .load_val(load_b_wr ? pwdata[HALF_W-1:0] : load_b_reg),
        .load_wr(load_b_wr & pair),
        .match_val(match_b_reg),
        .pin_in(cap_b_in),
        .count_reg(cnt_b),
        .timeout_pulse(to_b),
        .cap_event_pulse(ev_b),
        .cap_match_pulse(cm_b),
        .pwm_level(pwm_b)
    );

    // ****************************************
    // Pins and triggers
    // ****************************************
    // Capture pin turns into an output in PWM mode
    assign cap_a_oe = pair & (mode_a_reg[2:0] == `HALF_PWM);
    assign cap_b_oe = pair & (mode_b_reg[2:0] == `HALF_PWM);
    assign cap_a_out = pwm_a ^ ctl_reg[`CTL_INV];
    assign cap_b_out = pwm_b ^ ctl_reg[`CTL_INV + `CTL_B_SHIFT];
    // Trigger pulses follow the timeouts, and on A also the seconds match, when enabled
    assign trig_a = ctl_reg[`CTL_TRIG] & (to_a | wide_to_reg | rtc_hit_reg);
    assign trig_b = ctl_reg[`CTL_TRIG + `CTL_B_SHIFT] & to_b;

    // ****************************************
    // Wide counter and RTC
    // ****************************************
    wire wide_run = ~pair & en_a & ~halt_a;
    wire slow_rise = rtc_s2_reg & ~rtc_s3_reg;
    wire sec_tick = slow_rise & (prescale_reg == RTC_DIV - 1);

    // Slow clock synchroniser; the clock is sampled as data
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rtc_s1_reg <= 1'b0;
            rtc_s2_reg <= 1'b0;
            rtc_s3_reg <= 1'b0;
        end
        else
        begin
            rtc_s1_reg <= rtc_slow_clk;
            rtc_s2_reg <= rtc_s1_reg;
            rtc_s3_reg <= rtc_s2_reg;
        end
    end

    // Wide one-shot, periodic and seconds count
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wide_reg <= 32'h0000_0000;
            wide_stop_reg <= 1'b0;
            wide_to_reg <= 1'b0;
            rtc_hit_reg <= 1'b0;
            prescale_reg <= 32'h0000_0000;
        end
        else
        begin
            wide_to_reg <= 1'b0;
            rtc_hit_reg <= 1'b0;
            if (load_a_wr & ~pair)
            begin
                wide_reg <= pwdata;
                wide_stop_reg <= 1'b0;
                prescale_reg <= 32'h0000_0000;
            end
            else if (wide_run)
            begin
                case (cfg_reg)
                    `TOP_WIDE_ONE_SHOT:
                    begin
                        if (!wide_stop_reg && wide_reg == 32'h0000_0000)
                        begin
                            wide_stop_reg <= 1'b1;
                            wide_to_reg <= 1'b1;
                        end
                        else if (!wide_stop_reg)
                            wide_reg <= wide_reg - 32'h0000_0001;
                    end
                    `TOP_WIDE_PERIODIC:
                    begin
                        if (wide_reg == 32'h0000_0000)
                        begin
                            wide_reg <= load_a_reg;
                            wide_to_reg <= 1'b1;
                        end
                        else
                            wide_reg <= wide_reg - 32'h0000_0001;
                    end
                    `TOP_WIDE_RTC:
                    begin
                        // Count slow edges, one second per RTC_DIV of them
                        if (sec_tick)
                        begin
                            prescale_reg <= 32'h0000_0000;
                            wide_reg <= wide_reg + 32'h0000_0001;
                            rtc_hit_reg <= (wide_reg + 32'h0000_0001 == match_a_reg);
                        end
                        else if (slow_rise)
                            prescale_reg <= prescale_reg + 32'h0000_0001;
                    end
                    default:
                        wide_reg <= wide_reg;
                endcase
            end
        end
    end

    // ****************************************
    // Status and interrupt
    // ****************************************
    reg [31:0] ev_set;
    // Gather this cycle's events into status positions
    always @*
    begin
        ev_set = 32'h0000_0000;
        ev_set[`ST_A_TIMEOUT] = to_a | wide_to_reg;
        ev_set[`ST_A_CAP_MATCH] = cm_a;
        ev_set[`ST_A_CAP_EVENT] = ev_a;
        ev_set[`ST_RTC_MATCH] = rtc_hit_reg;
        ev_set[`ST_B_TIMEOUT] = to_b;
        ev_set[`ST_B_CAP_MATCH] = cm_b;
        ev_set[`ST_B_CAP_EVENT] = ev_b;
    end
    wire [31:0] ris_clr = (wr_ok & hit(paddr, `TMR_RIS_OFS)) ? pwdata : 32'h0000_0000;
    // Set beats clear so no event is lost
    wire [31:0] ris_next = ((ris_reg & ~ris_clr) | ev_set) & `ST_MASK;
    wire [31:0] mis = ris_reg & imr_reg;
    assign irq = |mis;

    // ****************************************
    // Register writes
    // ****************************************
    // Mode changes only while disabled; software's duty
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_reg <= `TOP_PAIR;
            mode_a_reg <= 6'h00;
            mode_b_reg <= 6'h00;
            ctl_reg <= 16'h0000;
            load_a_reg <= 32'h0000_0000;
            load_b_reg <= {HALF_W{1'b0}};
            match_a_reg <= 32'h0000_0000;
            match_b_reg <= {HALF_W{1'b0}};
            imr_reg <= 32'h0000_0000;
            ris_reg <= 32'h0000_0000;
        end
        else
        begin
            ris_reg <= ris_next;
            if (wr_ok)
            begin
                case (paddr)
                    `TMR_CFG_OFS: cfg_reg <= pwdata[1:0];
                    `TMR_MODE_A_OFS: mode_a_reg <= pwdata[5:0];
                    `TMR_MODE_B_OFS: mode_b_reg <= pwdata[5:0];
                    `TMR_CTL_OFS: ctl_reg <= pwdata[15:0] & 16'h0F0F;
                    `TMR_LOAD_A_OFS: load_a_reg <= pwdata;
                    `TMR_LOAD_B_OFS: load_b_reg <= pwdata[HALF_W-1:0];
                    `TMR_MATCH_A_OFS: match_a_reg <= pwdata;
                    `TMR_MATCH_B_OFS: match_b_reg <= pwdata[HALF_W-1:0];
                    `TMR_IMR_OFS: imr_reg <= pwdata & `ST_MASK;
                    default: imr_reg <= imr_reg;
                endcase
            end
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    reg [31:0] rd_mux;
    // Select read word; unmapped reads zero
    always @*
    begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `TMR_CFG_OFS: rd_mux = {30'h0000_0000, cfg_reg};
            `TMR_MODE_A_OFS: rd_mux = {26'h000_0000, mode_a_reg};
            `TMR_MODE_B_OFS: rd_mux = {26'h000_0000, mode_b_reg};
            `TMR_CTL_OFS: rd_mux = {16'h0000, ctl_reg};
            `TMR_LOAD_A_OFS: rd_mux = load_a_reg;
            `TMR_LOAD_B_OFS: rd_mux = {{(32-HALF_W){1'b0}}, load_b_reg};
            `TMR_MATCH_A_OFS: rd_mux = match_a_reg;
            `TMR_MATCH_B_OFS: rd_mux = {{(32-HALF_W){1'b0}}, match_b_reg};
            `TMR_IMR_OFS: rd_mux = imr_reg;
            `TMR_RIS_OFS: rd_mux = ris_reg;
            `TMR_MIS_OFS: rd_mux = mis;
            `TMR_VAL_A_OFS: rd_mux = pair ? {{(32-HALF_W){1'b0}}, cnt_a} : wide_reg;
            `TMR_VAL_B_OFS: rd_mux = {{(32-HALF_W){1'b0}}, cnt_b};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data captured in the setup cycle, held through access
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (setup & ~pwrite)
            prdata <= rd_mux;
    end
endmodule
`default_nettype wire

// *** hdl/dual_timer_map.vh ***
`ifndef DUAL_TIMER_MAP_VH
`define DUAL_TIMER_MAP_VH
// ****************************************
// Register byte offsets
// ****************************************
`define TMR_CFG_OFS 8'h00
`define TMR_MODE_A_OFS 8'h04
`define TMR_MODE_B_OFS 8'h08
`define TMR_CTL_OFS 8'h0C
`define TMR_LOAD_A_OFS 8'h10
`define TMR_LOAD_B_OFS 8'h14
`define TMR_MATCH_A_OFS 8'h18
`define TMR_MATCH_B_OFS 8'h1C
`define TMR_IMR_OFS 8'h20
`define TMR_RIS_OFS 8'h24
`define TMR_MIS_OFS 8'h28
`define TMR_VAL_A_OFS 8'h2C
`define TMR_VAL_B_OFS 8'h30
// ****************************************
// Top-level modes
// ****************************************
`define TOP_PAIR 2'h0
`define TOP_WIDE_ONE_SHOT 2'h1
`define TOP_WIDE_PERIODIC 2'h2
`define TOP_WIDE_RTC 2'h3
// ****************************************
// Half modes
// ****************************************
`define HALF_ONE_SHOT 3'h0
`define HALF_PERIODIC 3'h1
`define HALF_EDGE_COUNT 3'h2
`define HALF_EDGE_TIME 3'h3
`define HALF_PWM 3'h4
// ****************************************
// Edge selection
// ****************************************
`define EDGE_RISE 2'h0
`define EDGE_FALL 2'h1
`define EDGE_BOTH 2'h2
// ****************************************
// Control bit positions (B half adds 8)
// ****************************************
`define CTL_EN 0
`define CTL_INV 1
`define CTL_STALL 2
`define CTL_TRIG 3
`define CTL_B_SHIFT 8
// ****************************************
// Status bit positions
// ****************************************
`define ST_A_TIMEOUT 0
`define ST_A_CAP_MATCH 1
`define ST_A_CAP_EVENT 2
`define ST_RTC_MATCH 3
`define ST_B_TIMEOUT 8
`define ST_B_CAP_MATCH 9
`define ST_B_CAP_EVENT 10
`define ST_MASK 32'h0000_070F
// ****************************************
// Timing
// ****************************************
`define RTC_SLOW_HZ 32768
`define RTC_TICK_S 1
`define RTC_DIV (`RTC_SLOW_HZ * `RTC_TICK_S)
`endif

// *** hdl/timer_half.v ***
`include "dual_timer_map.vh"
`default_nettype none
// ****************************************
// One 16-bit half counter
// ****************************************
module timer_half #(
    parameter WIDTH = 16
) (
    input wire pclk,
    input wire presetn,
    input wire run,
    input wire [2:0] mode,
    input wire [1:0] edge_sel,
    input wire [WIDTH-1:0] load_val,
    input wire load_wr,
    input wire [WIDTH-1:0] match_val,
    input wire pin_in,
    output reg [WIDTH-1:0] count_reg,
    output reg timeout_pulse,
    output reg cap_event_pulse,
    output reg cap_match_pulse,
    output reg pwm_level
);
    reg sync1_reg; // First synchroniser stage, read only by the second
    reg sync2_reg;
    reg sync3_reg; // Previous synced level for edge detection
    reg stopped_reg; // One-shot has expired
    wire rise = sync2_reg & ~sync3_reg;
    wire fall = ~sync2_reg & sync3_reg;
    // Selected edge of the capture input
    wire edge_hit = (edge_sel == `EDGE_RISE) ? rise :
                    (edge_sel == `EDGE_FALL) ? fall : (rise | fall);
    wire at_zero = (count_reg == {WIDTH{1'b0}});
    reg [WIDTH-1:0] free_reg; // Free-running time base for edge timing

    // Pin synchroniser
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // Counter core per mode
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_reg <= {WIDTH{1'b0}};
            free_reg <= {WIDTH{1'b0}};
            stopped_reg <= 1'b0;
            timeout_pulse <= 1'b0;
            cap_event_pulse <= 1'b0;
            cap_match_pulse <= 1'b0;
            pwm_level <= 1'b0;
        end
        else
        begin
            timeout_pulse <= 1'b0;
            cap_event_pulse <= 1'b0;
            cap_match_pulse <= 1'b0;
            if (load_wr)
            begin
                // New load takes effect at once, even mid-count
                count_reg <= load_val;
                stopped_reg <= 1'b0;
            end
            else if (run)
            begin
                case (mode)
                    `HALF_ONE_SHOT:
                    begin
                        // Hold at zero once expired
                        if (!stopped_reg && at_zero)
                        begin
                            stopped_reg <= 1'b1;
                            timeout_pulse <= 1'b1;
                        end
                        else if (!stopped_reg)
                            count_reg <= count_reg - 1'b1;
                    end
                    `HALF_PERIODIC:
                    begin
                        // Reload and keep going
                        if (at_zero)
                        begin
                            count_reg <= load_val;
                            timeout_pulse <= 1'b1;
                        end
                        else
                            count_reg <= count_reg - 1'b1;
                    end
                    `HALF_EDGE_COUNT:
                    begin
                        // Count edges down towards the match value
                        if (edge_hit)
                        begin
                            cap_event_pulse <= 1'b1;
                            if (count_reg - 1'b1 == match_val)
                            begin
                                cap_match_pulse <= 1'b1;
                                count_reg <= load_val;
                            end
                            else
                                count_reg <= count_reg - 1'b1;
                        end
                    end
                    `HALF_EDGE_TIME:
                    begin
                        // Latch the free-running time at each selected edge
                        free_reg <= free_reg - 1'b1;
                        if (edge_hit)
                        begin
                            count_reg <= free_reg;
                            cap_event_pulse <= 1'b1;
                        end
                    end
                    `HALF_PWM:
                    begin
                        // Edge-aligned: high from reload until match
                        if (at_zero)
                        begin
                            count_reg <= load_val;
                            timeout_pulse <= 1'b1;
                        end
                        else
                            count_reg <= count_reg - 1'b1;
                        pwm_level <= (count_reg > match_val);
                    end
                    default:
                        count_reg <= count_reg;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// *** sim/dual_timer_checker.sv ***
`default_nettype none
// ****
// Port checks
// ****
module dual_timer_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic trig_a,
    input wire logic trig_b,
    input wire logic cap_a_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // Misaligned or past the last word
    wire unmap = (paddr[1:0] != 2'h0) || (paddr > 8'h30);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Read setup, then access phase
    sequence rd_setup;
        psel && !penable && !pwrite;
    endsequence
    sequence access;
        psel && penable;
    endsequence
    ready_high_a: assert property (access |-> pready)
        else $error("pready low in access");
    misalign_err_a: assert property (access ##0 (paddr[1:0] != 2'h0) |-> pslverr)
        else $error("no error on misaligned address");
    range_err_a: assert property (access ##0 (paddr > 8'h30) |-> pslverr)
        else $error("no error past last word");
    mapped_ok_a: assert property (access ##0 !unmap |-> !pslverr)
        else $error("error on mapped word");
    unmap_zero_a: assert property (rd_setup ##0 unmap |=> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    // Read data only moves after a read setup
    rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
    trig_a_pulse_a: assert property (trig_a |=> !trig_a)
        else $error("trigger A longer than one cycle");
    trig_b_pulse_a: assert property (trig_b |=> !trig_b)
        else $error("trigger B longer than one cycle");
    // Pin direction only changes through a write
    oe_by_write_a: assert property ($changed(cap_a_oe) |-> $past(psel && penable && pwrite))
        else $error("pin direction changed without write");
endmodule
bind dual_timer_capture_pwm dual_timer_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .trig_a(trig_a), .trig_b(trig_b), .cap_a_oe(cap_a_oe));
`default_nettype wire

// *** sim/pin_partner.sv ***
`default_nettype none
// ****
// Capture pins and slow clock source
// ****
module pin_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic rtc_run,
    input wire logic cap_a_out,
    input wire logic cap_a_oe,
    input wire logic cap_b_out,
    input wire logic cap_b_oe,
    input wire logic lvl_b,
    output logic cap_a_in,
    output logic cap_b_in,
    output logic rtc_slow_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] div; // Half period count
    // Pin A has a pull-down while released
    assign cap_a_in = cap_a_oe ? cap_a_out : 1'b0;
    assign cap_b_in = cap_b_oe ? cap_b_out : lvl_b;
    // Sped up to keep runs short; low when idle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn || !rtc_run)
        begin
            div <= 3'h0;
            rtc_slow_clk <= 1'b0;
        end
        else if (div == 3'h4)
        begin
            div <= 3'h0;
            rtc_slow_clk <= ~rtc_slow_clk;
        end
        else
            div <= div + 3'h1;
    end
endmodule
`default_nettype wire

// *** sim/dual_timer_capture_pwm_tb_top.sv ***
`include "dual_timer_map.vh"
`default_nettype none
module dual_timer_capture_pwm_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // Stimulus and wiring
    // ****
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, debug_halt = 0;
    logic rtc_run = 0, lvl_b = 0, serr;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, rdat;
    wire logic pready, pslverr, rtc_slow_clk, cap_a_in, cap_a_out, cap_a_oe, irq;
    wire logic cap_b_in, cap_b_out, cap_b_oe, trig_a, trig_b;
    wire logic [31:0] prdata;
    int failures = 0, num_checks = 0, ntrig = 0, nhigh = 0, n0, n1;
    always #10 pclk = ~pclk;
    dual_timer_capture_pwm #(.HALF_W(16), .RTC_DIV(4)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .debug_halt(debug_halt),
        .rtc_slow_clk(rtc_slow_clk), .cap_a_in(cap_a_in), .cap_a_out(cap_a_out), .cap_a_oe(cap_a_oe),
        .cap_b_in(cap_b_in), .cap_b_out(cap_b_out), .cap_b_oe(cap_b_oe), .trig_a(trig_a),
        .trig_b(trig_b), .irq(irq));
    pin_partner far (.pclk(pclk), .presetn(presetn), .rtc_run(rtc_run), .cap_a_out(cap_a_out),
        .cap_a_oe(cap_a_oe), .cap_b_out(cap_b_out), .cap_b_oe(cap_b_oe), .lvl_b(lvl_b),
        .cap_a_in(cap_a_in), .cap_b_in(cap_b_in), .rtc_slow_clk(rtc_slow_clk));
    // Counted on the falling edge, away from the launch edge
    always @(negedge pclk)
    begin
        ntrig += (trig_a === 1'b1);
        nhigh += (cap_a_out === 1'b1);
    end
    // ****
    // Tasks
    // ****
    task automatic tick(int n);
        repeat (n) @(posedge pclk);
    endtask
    // One APB transfer; holds the request until pready
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d = 32'h0);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Disable, clear, configure, enable
    task automatic setup(logic [1:0] c, logic [7:0] mo, logic [31:0] m, logic [7:0] lo,
        logic [31:0] l, logic [31:0] ct);
        apb(1, `TMR_CTL_OFS, 32'h0);
        apb(1, `TMR_RIS_OFS, 32'hFFFF_FFFF);
        apb(1, `TMR_CFG_OFS, {30'h0, c});
        apb(1, mo, m);
        apb(1, lo, l);
        apb(1, `TMR_CTL_OFS, ct);
    endtask
    task automatic summarize();
        if (failures == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard, well past the run
    initial
    begin
        repeat (8000) @(posedge pclk);
        failures++;
        summarize();
    end
    // ****
    // Test sequence
    // ****
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `TMR_CTL_OFS);
        chk("ctl_reset", 32'h0, rdat);
        apb(0, 8'h34);
        chk("unmapped_read", 32'h0, rdat);
        chk("unmapped_err", 32'h1, {31'h0, serr});
        // Half periodic, wide one-shot and periodic; B mode unused
        for (int t = 0; t < 3; t++)
        begin
            setup(t, t == 0 ? `TMR_MODE_A_OFS : `TMR_MODE_B_OFS, t == 0 ? `HALF_PERIODIC : `HALF_PWM,
                `TMR_LOAD_A_OFS, 32'h3, 32'h9);
            n0 = ntrig;
            tick(8);
            n1 = ntrig;
            tick(40);
            chk("trig_count", t == 1 ? 1 : 10, ntrig - (t == 1 ? n0 : n1));
        end
        // Debug stall on and off
        debug_halt <= 1'b1;
        apb(1, `TMR_CTL_OFS, 32'hD);
        n0 = ntrig;
        tick(40);
        chk("stalled", 0, ntrig - n0);
        apb(1, `TMR_CTL_OFS, 32'h9);
        tick(8);
        n0 = ntrig;
        tick(40);
        chk("not_stalled", 10, ntrig - n0);
        debug_halt <= 1'b0;
        apb(1, `TMR_CTL_OFS, 32'h0);
        apb(1, `TMR_LOAD_A_OFS, 32'h0001_0000);
        apb(0, `TMR_VAL_A_OFS);
        chk("wide_value", 32'h0001_0000, rdat);
        // Half one-shot with masking
        apb(1, `TMR_IMR_OFS, 32'h1);
        setup(0, `TMR_MODE_A_OFS, `HALF_ONE_SHOT, `TMR_LOAD_A_OFS, 32'h5, 32'h9);
        n0 = ntrig;
        tick(30);
        chk("one_shot", 1, ntrig - n0);
        apb(0, `TMR_VAL_A_OFS);
        chk("stopped_value", 32'h0, rdat);
        chk("irq_on", 32'h1, {31'h0, irq});
        apb(1, `TMR_IMR_OFS, 32'h0);
        tick(1);
        chk("irq_masked", 32'h0, {31'h0, irq});
        apb(0, `TMR_RIS_OFS);
        chk("raw_status", 32'h1, rdat & `ST_MASK);
        apb(0, `TMR_MIS_OFS);
        chk("masked_status", 32'h0, rdat);
        apb(1, `TMR_RIS_OFS, 32'h1);
        apb(0, `TMR_RIS_OFS);
        chk("status_clear", 32'h0, rdat & `ST_MASK);
        apb(1, `TMR_LOAD_A_OFS, 32'h5);
        n0 = ntrig;
        tick(30);
        chk("rearm", 1, ntrig - n0);
        // PWM duty, plain and inverted
        apb(1, `TMR_MATCH_A_OFS, 32'h2);
        setup(0, `TMR_MODE_A_OFS, `HALF_PWM, `TMR_LOAD_A_OFS, 32'h9, 32'h1);
        for (int i = 0; i < 2; i++)
        begin
            apb(1, `TMR_CTL_OFS, i ? 32'h3 : 32'h1);
            tick(5);
            n0 = nhigh;
            tick(20);
            chk("pwm_high", i ? 6 : 14, nhigh - n0);
            chk("pwm_drive", 32'h1, {31'h0, cap_a_oe});
        end
        // Edge count on B for each edge choice
        apb(1, `TMR_MATCH_B_OFS, 32'h3);
        for (int e = 0; e < 3; e++)
        begin
            setup(0, `TMR_MODE_B_OFS, 32'h2 | (e << 4), `TMR_LOAD_B_OFS, 32'h5, 32'h100);
            apb(0, `TMR_VAL_B_OFS);
            chk("load_b", 32'h5, rdat);
            lvl_b <= 1'b1;
            tick(6);
            apb(0, `TMR_RIS_OFS);
            chk("rise_event", 32'(e != 1) << 10, rdat & `ST_MASK);
            apb(1, `TMR_RIS_OFS, 32'hFFFF_FFFF);
            lvl_b <= 1'b0;
            tick(6);
            apb(0, `TMR_RIS_OFS);
            chk("fall_event", (32'(e != 0) << 10) | (32'(e == 2) << 9), rdat & `ST_MASK);
        end
        // Wide seconds counter: nine slow edges give two seconds
        setup(`TOP_WIDE_RTC, `TMR_MATCH_A_OFS, 32'h2, `TMR_LOAD_A_OFS, 32'h0, 32'h1);
        apb(1, `TMR_IMR_OFS, 32'h8);
        rtc_run <= 1'b1;
        tick(90);
        rtc_run <= 1'b0;
        tick(10);
        apb(0, `TMR_VAL_A_OFS);
        chk("seconds", 32'h2, rdat);
        apb(0, `TMR_MIS_OFS);
        chk("rtc_match", 32'h8, rdat);
        summarize();
    end
endmodule
`default_nettype wire
